// ### core/ccm_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time
// assumes the owner decodes addresses and returns read data combinationally
module ccm_axil_slave
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_q, w_q;

   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;
   assign wr_en = aw_q && w_q;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_en = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_en)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? ccm_pkg::RESP_OKAY : ccm_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (rd_en)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
         s_axi_rresp <= rd_ok ? ccm_pkg::RESP_OKAY : ccm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// ### core/ccm_monitor.sv
// command channel supervision, forced local handling and state word
// assumes channel writes, warnings and stop_done come from clock-domain
// logic; forced_local and stop_key are pins
// Functional notes
// - each channel keeps its own control word; only the active one acts
// - supervise a channel only if it feeds active or selector word
// - supervision of a channel starts at first supervised word write
// - warning on a supervised channel raises a communication interruption
// - warning on an unsupervised channel raises nothing
// - interruption applies the configured response
// - channel enabled after any write outside forced local; motor starts only if enabled
// - standard profile: command written before switched on to enabled
// - enabled cleared by a warning and during forced local
// - leaving forced local copies run word into active channel
// - supervision resumes only after the resume delay elapses
// - remote control acts only after a fresh active command
// - operating state word bit meanings as fixed layout
// - active channel identity and its control word are readable
// - process image shows only words carried by the object
// - responses: freewheel fault, decel fault, brake fault, ignore, stop
module ccm_monitor
#(
   parameter int unsigned TICK_CYCLES = ccm_pkg::TICK_CYCLES
)
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel control word writes
   input wire logic [2:0] ch_wr,
   input wire logic ch_wr_ext,
   input wire logic [15:0] ch_wr_data,
   input wire logic [2:0] comm_warn,
   // local panel
   input wire logic forced_local,
   input wire logic stop_key,
   input wire logic [15:0] local_run_word,
   // motor side
   input wire logic stop_done,
   output logic motor_run,
   output logic [1:0] stop_mode,
   output logic fault,
   output logic comm_intr,
   output logic [1:0] active_channel,
   // process image
   input wire logic pdo_load,
   input wire logic [3:0] pdo_bytes,
   input wire logic [63:0] pdo_data,
   // interrupt
   output logic irq
);
   typedef enum logic [2:0] {
      ST_DISABLED, ST_READY, ST_ON, ST_RUN, ST_STOP, ST_FAULT
   } ccm_state_t;

   logic wr_en, rd_en, rd_ok;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [31:0] ctrl_q, delay_q, mask_q;
   logic [3:0] irq_q, irq_ev;
   logic [15:0] cw_q [3];
   logic [15:0] ext_q, cmd, osw;
   logic [15:0] pdo_q [4];
   logic [3:0] pdo_len_q;
   logic [2:0] mon_q, en_q, involved, sup_wr, sup_now;
   logic [1:0] act, sel;
   logic fl_s1_q, fl_q, fl_d1_q, key_s1_q, key_q;
   logic fl_exit, intr_d, intr_q, fresh_q, warn_q, stop_fault_q;
   logic remote_ok, resume;
   logic [15:0] rs_ms_q;
   logic [14:0] rs_tick_q;
   ccm_pkg::ccm_resp_t resp;
   ccm_state_t state_q;

   function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   function automatic logic [2:0] ch_bit(input logic [1:0] c);
      ch_bit = (c == 2'h3) ? 3'h0 : 3'(3'h1 << c);
   endfunction

   ccm_axil_slave u_ccm_axil_slave (
      .clock(clock), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_strb(wr_strb), .wr_ok(1'b1), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_ok(rd_ok)
   );

   // software registers
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= ccm_pkg::CTRL_RST;
         delay_q <= ccm_pkg::DELAY_RST;
         mask_q <= ccm_pkg::MASK_RST;
      end
      else if (wr_en)
      begin
         if (wr_addr == ccm_pkg::A_CTRL)
            ctrl_q <= wmerge(ctrl_q, wr_data, wr_strb);
         if (wr_addr == ccm_pkg::A_DELAY)
            delay_q <= wmerge(delay_q, wr_data, wr_strb);
         if (wr_addr == ccm_pkg::A_MASK)
            mask_q <= wmerge(mask_q, wr_data, wr_strb);
      end
   end

   assign act = ctrl_q[ccm_pkg::CTRL_ACT +: 2];
   assign sel = ctrl_q[ccm_pkg::CTRL_SEL +: 2];
   assign resp = ccm_pkg::ccm_resp_t'(ctrl_q[ccm_pkg::CTRL_RESP +: 3]);
   assign active_channel = act;

   // pin synchronisers
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         fl_s1_q <= 1'b0;
         fl_q <= 1'b0;
         fl_d1_q <= 1'b0;
         key_s1_q <= 1'b0;
         key_q <= 1'b0;
      end
      else
      begin
         fl_s1_q <= forced_local;
         fl_q <= fl_s1_q;
         fl_d1_q <= fl_q;
         key_s1_q <= stop_key;
         key_q <= key_s1_q;
      end
   end

   assign fl_exit = fl_d1_q && !fl_q;

   // supervised words and supervision gating
   assign involved = ch_bit(act) |
      (ctrl_q[ccm_pkg::CTRL_SEL_EXT] ? 3'h0 : ch_bit(sel));
   assign sup_wr = ch_wr & (ch_wr_ext ?
      (ctrl_q[ccm_pkg::CTRL_SEL_EXT] ? ch_bit(sel) : 3'h0) : involved);
   assign resume = rs_ms_q != 16'h0000;
   assign sup_now = mon_q & (involved |
      (ctrl_q[ccm_pkg::CTRL_SEL_EXT] ? ch_bit(sel) : 3'h0)) &
      {3{!fl_q && !resume}};
   assign intr_d = |(comm_warn & sup_now);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mon_q <= 3'h0;
         intr_q <= 1'b0;
      end
      else
      begin
         mon_q <= mon_q | sup_wr;
         intr_q <= intr_d;
      end
   end
   assign comm_intr = intr_q;

   // channel enable, a new write wins over a warning
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         en_q <= 3'h0;
      else
         for (int c = 0; c < 3; c++)
            if (ch_wr[c] && !fl_q)
               en_q[c] <= 1'b1;
            else if (comm_warn[c] || fl_q)
               en_q[c] <= 1'b0;
   end

   // per channel control words
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int c = 0; c < 3; c++)
            cw_q[c] <= 16'h0000;
         ext_q <= 16'h0000;
      end
      else
      begin
         if (fl_exit && act != 2'h3)
            cw_q[act] <= local_run_word;
         for (int c = 0; c < 3; c++)
            if (ch_wr[c] && !ch_wr_ext)
               cw_q[c] <= ch_wr_data;
         if (|ch_wr && ch_wr_ext)
            ext_q <= ch_wr_data;
      end
   end

   assign cmd = (act == 2'h3) ? 16'h0000 : cw_q[act];

   // fresh remote command tracking
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         fresh_q <= 1'b0;
      else if (fl_q)
         fresh_q <= 1'b0;
      else if (|(ch_wr & ch_bit(act)) && !ch_wr_ext)
         fresh_q <= 1'b1;
   end
   assign remote_ok = fresh_q && !fl_q;

   // resume delay after forced local
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rs_ms_q <= 16'h0000;
         rs_tick_q <= 15'h0000;
      end
      else if (fl_q)
      begin
         rs_ms_q <= 16'h0000;
         rs_tick_q <= 15'h0000;
      end
      else if (fl_exit)
      begin
         rs_ms_q <= delay_q[15:0];
         rs_tick_q <= 15'h0000;
      end
      else if (resume)
      begin
         if (rs_tick_q == 15'(TICK_CYCLES - 1))
         begin
            rs_tick_q <= 15'h0000;
            rs_ms_q <= rs_ms_q - 16'h0001;
         end
         else
            rs_tick_q <= rs_tick_q + 15'h0001;
      end
   end

   // drive state machine
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_DISABLED;
         stop_mode <= ccm_pkg::STOP_NONE;
         stop_fault_q <= 1'b0;
      end
      else if (intr_q && resp != ccm_pkg::RESP_IGNORE &&
         state_q != ST_FAULT)
      begin
         unique case (resp)
            ccm_pkg::RESP_DECEL, ccm_pkg::RESP_BRAKE:
            begin
               state_q <= (state_q == ST_RUN) ? ST_STOP : ST_FAULT;
               stop_mode <= (resp == ccm_pkg::RESP_DECEL) ?
                  ccm_pkg::STOP_DECEL : ccm_pkg::STOP_BRAKE;
               stop_fault_q <= 1'b1;
            end
            ccm_pkg::RESP_STOP:
               if (state_q == ST_RUN)
               begin
                  state_q <= ST_STOP;
                  stop_mode <= ccm_pkg::STOP_DECEL;
                  stop_fault_q <= 1'b0;
               end
            default:
            begin
               state_q <= ST_FAULT;
               stop_mode <= ccm_pkg::STOP_FREEWHEEL;
            end
         endcase
      end
      else
      begin
         unique case (state_q)
            ST_DISABLED:
               if (remote_ok && cmd[ccm_pkg::CW_VOLT] &&
                  cmd[ccm_pkg::CW_QSTOP_N] && !cmd[ccm_pkg::CW_SWON])
                  state_q <= ST_READY;
            ST_READY:
               if (remote_ok && !(cmd[ccm_pkg::CW_VOLT] &&
                  cmd[ccm_pkg::CW_QSTOP_N]))
                  state_q <= ST_DISABLED;
               else if (remote_ok && cmd[ccm_pkg::CW_SWON])
                  state_q <= ST_ON;
            ST_ON:
               if (remote_ok && !cmd[ccm_pkg::CW_SWON])
                  state_q <= ST_READY;
               else if (remote_ok && en_q[act] && !key_q &&
                  (!ctrl_q[ccm_pkg::CTRL_PROFILE] || cmd[ccm_pkg::CW_ENOP]))
                  state_q <= ST_RUN;
            ST_RUN:
               if (key_q)
               begin
                  state_q <= ST_STOP;
                  stop_mode <= ccm_pkg::STOP_DECEL;
                  stop_fault_q <= 1'b0;
               end
               else if (remote_ok && !(cmd[ccm_pkg::CW_ENOP] &&
                  cmd[ccm_pkg::CW_SWON]))
                  state_q <= ST_ON;
            ST_STOP:
               if (stop_done)
               begin
                  state_q <= stop_fault_q ? ST_FAULT : ST_ON;
                  stop_mode <= ccm_pkg::STOP_NONE;
               end
            ST_FAULT:
               if (remote_ok && cmd[ccm_pkg::CW_FRST])
               begin
                  state_q <= ST_DISABLED;
                  stop_mode <= ccm_pkg::STOP_NONE;
                  stop_fault_q <= 1'b0;
               end
         endcase
      end
   end

   assign motor_run = state_q == ST_RUN;
   assign fault = state_q == ST_FAULT;

   // warning held while ignore mode masks interruptions
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         warn_q <= 1'b0;
      else
         warn_q <= (intr_q && resp == ccm_pkg::RESP_IGNORE) ||
            (warn_q && |comm_warn);
   end

   // operating state word
   always_comb
   begin
      osw = 16'h0000;
      osw[ccm_pkg::OSW_READY] = state_q inside {ST_READY, ST_ON, ST_RUN};
      osw[ccm_pkg::OSW_ON] = state_q inside {ST_ON, ST_RUN};
      osw[ccm_pkg::OSW_RUN] = state_q == ST_RUN;
      osw[ccm_pkg::OSW_ERR] = state_q == ST_FAULT;
      osw[ccm_pkg::OSW_VOLT] = state_q inside {ST_READY, ST_ON, ST_RUN};
      osw[ccm_pkg::OSW_QSTOP_N] = state_q != ST_STOP;
      osw[ccm_pkg::OSW_DIS] = state_q == ST_DISABLED;
      osw[ccm_pkg::OSW_WARN] = warn_q;
      osw[ccm_pkg::OSW_REMOTE] = !fl_q;
      osw[ccm_pkg::OSW_KEY] = key_q;
   end

   // process image capture
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int w = 0; w < 4; w++)
            pdo_q[w] <= 16'h0000;
         pdo_len_q <= 4'h0;
      end
      else if (pdo_load)
      begin
         for (int w = 0; w < 4; w++)
            pdo_q[w] <= pdo_data[16*w +: 16];
         pdo_len_q <= pdo_bytes;
      end
   end

   // sticky events, read of the interrupt status register clears, set wins
   assign irq_ev = {fl_exit, intr_q && resp != ccm_pkg::RESP_IGNORE,
      intr_q && resp == ccm_pkg::RESP_IGNORE, intr_q};
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         irq_q <= 4'h0;
      else if (rd_en && rd_addr == ccm_pkg::A_IRQ)
         irq_q <= irq_ev;
      else
         irq_q <= irq_q | irq_ev;
   end
   assign irq = |(irq_q & mask_q[3:0]);

   // read decode
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (rd_addr)
         ccm_pkg::A_CTRL: rd_data = ctrl_q;
         ccm_pkg::A_DELAY: rd_data = delay_q;
         ccm_pkg::A_STATUS:
            rd_data = {21'h0, remote_ok, resume, fl_q, act, en_q, mon_q};
         ccm_pkg::A_CMD: rd_data = {16'h0000, cmd};
         ccm_pkg::A_CWI0: rd_data = {16'h0000, cw_q[0]};
         ccm_pkg::A_CWI1: rd_data = {16'h0000, cw_q[1]};
         ccm_pkg::A_CWI2: rd_data = {16'h0000, cw_q[2]};
         ccm_pkg::A_EXT: rd_data = {16'h0000, ext_q};
         ccm_pkg::A_OSW: rd_data = {16'h0000, osw};
         ccm_pkg::A_IRQ: rd_data = {28'h0, irq_q};
         ccm_pkg::A_MASK: rd_data = mask_q;
         8'h2C, 8'h30, 8'h34, 8'h38:
            if ({rd_addr[3:2] - 2'h3, 1'b1} < pdo_len_q[2:0] ||
               pdo_len_q[3])
               rd_data = {16'h0000, pdo_q[2'(rd_addr[3:2] - 2'h3)]};
         default: rd_ok = 1'b0;
      endcase
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_mon_on_write: assert property (sup_wr[0] |=> mon_q[0])
      else $error("supervision not started by write");
   a_no_mon_early: assert property (
      !mon_q[1] && !sup_wr[1] |=> !mon_q[1])
      else $error("supervision started without write");
   a_unsup_quiet: assert property (
      (comm_warn & sup_now) == 3'h0 |=> !comm_intr)
      else $error("interruption from unsupervised channel");
   a_intr_fault: assert property (
      comm_intr && resp == ccm_pkg::RESP_FREEWHEEL && !fault |=>
      fault && stop_mode == ccm_pkg::STOP_FREEWHEEL)
      else $error("freewheel response missing");
   a_run_needs_en: assert property (
      $rose(motor_run) |-> $past(en_q[act]) && $past(fresh_q))
      else $error("start without enabled channel");
   a_warn_disables: assert property (
      comm_warn[2] && !ch_wr[2] |=> !en_q[2])
      else $error("warning left channel enabled");
   a_local_copy: assert property (
      $fell(fl_q) && act == 2'h0 ##1 !$past(ch_wr[0]) |->
      cw_q[0] == $past(local_run_word))
      else $error("run word not copied on exit");
   a_resume_quiet: assert property (
      fl_exit && delay_q[15:0] != 16'h0000 |=> resume && sup_now == 3'h0)
      else $error("supervision resumed early");
   a_fresh_needed: assert property (
      fl_exit |-> !fresh_q ##1 !$rose(motor_run))
      else $error("remote acted without fresh command");
   a_osw_run: assert property (
      osw[ccm_pkg::OSW_RUN] |-> osw[ccm_pkg::OSW_ON] &&
      osw[ccm_pkg::OSW_READY] && !osw[ccm_pkg::OSW_DIS])
      else $error("state word mismatch");

   c_intr: cover property (comm_intr ##[1:20] fault);
   c_run: cover property ($rose(motor_run));
   c_resume: cover property (fl_exit ##[1:100] !resume);
endmodule

// ### pkg/ccm_pkg.sv
// constants, field layouts and register map of the channel monitor
// assumes a single 20 MHz clock and an AXI4-Lite register port
package ccm_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned DELAY_UNIT_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;

   // channel indices
   localparam logic [1:0] CH_SERIAL = 2'h0;
   localparam logic [1:0] CH_CANBUS = 2'h1;
   localparam logic [1:0] CH_MODULE = 2'h2;

   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_DELAY = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_CMD = 8'h0C;
   localparam logic [7:0] A_CWI0 = 8'h10;
   localparam logic [7:0] A_CWI1 = 8'h14;
   localparam logic [7:0] A_CWI2 = 8'h18;
   localparam logic [7:0] A_EXT = 8'h1C;
   localparam logic [7:0] A_OSW = 8'h20;
   localparam logic [7:0] A_IRQ = 8'h24;
   localparam logic [7:0] A_MASK = 8'h28;
   localparam logic [7:0] A_PDO0 = 8'h2C;

   // control register fields
   localparam int CTRL_ACT = 0;
   localparam int CTRL_SEL = 2;
   localparam int CTRL_SEL_EXT = 4;
   localparam int CTRL_RESP = 5;
   localparam int CTRL_PROFILE = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0100;
   localparam logic [31:0] DELAY_RST = 32'h0000_0064;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;

   // control word bits
   localparam int CW_SWON = 0;
   localparam int CW_VOLT = 1;
   localparam int CW_QSTOP_N = 2;
   localparam int CW_ENOP = 3;
   localparam int CW_FRST = 7;

   // operating state word bits
   localparam int OSW_READY = 0;
   localparam int OSW_ON = 1;
   localparam int OSW_RUN = 2;
   localparam int OSW_ERR = 3;
   localparam int OSW_VOLT = 4;
   localparam int OSW_QSTOP_N = 5;
   localparam int OSW_DIS = 6;
   localparam int OSW_WARN = 7;
   localparam int OSW_REMOTE = 9;
   localparam int OSW_KEY = 14;

   // interrupt status bits
   localparam int IRQ_INTR = 0;
   localparam int IRQ_WARN = 1;
   localparam int IRQ_FAULT = 2;
   localparam int IRQ_RESUME = 3;

   typedef enum logic [2:0] {
      RESP_FREEWHEEL, RESP_DECEL, RESP_BRAKE, RESP_IGNORE, RESP_STOP
   } ccm_resp_t;

   localparam logic [1:0] STOP_NONE = 2'h0;
   localparam logic [1:0] STOP_FREEWHEEL = 2'h1;
   localparam logic [1:0] STOP_DECEL = 2'h2;
   localparam logic [1:0] STOP_BRAKE = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verif/ccm_ctrl_model.sv
// fieldbus controller model: control word writes and warnings
// assumes calls arrive just after a rising clock edge
module ccm_ctrl_model
(
   // channel side
   input wire logic clock,
   output logic [2:0] ch_wr,
   output logic ch_wr_ext,
   output logic [15:0] ch_wr_data,
   output logic [2:0] comm_warn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      ch_wr = 3'h0;
      ch_wr_ext = 1'b0;
      ch_wr_data = 16'h0000;
      comm_warn = 3'h0;
   end
   // one-cycle write strobe, data scrambled once released
   task automatic send(input int c, input logic [15:0] d);
      ch_wr[c] <= 1'b1;
      ch_wr_data <= d;
      @(posedge clock);
      ch_wr <= 3'h0;
      ch_wr_data <= ~d;
      @(posedge clock);
   endtask
   // extended word on the same strobe
   task automatic send_ext(input int c, input logic [15:0] d);
      ch_wr_ext <= 1'b1;
      send(c, d);
      ch_wr_ext <= 1'b0;
   endtask
   task automatic warn(input int c, input int n);
      comm_warn[c] <= 1'b1;
      repeat (n) @(posedge clock);
      comm_warn <= 3'h0;
   endtask
endmodule

// ### verif/tb_ccm_monitor.sv
// self-checking bench of the channel monitor over AXI4-Lite
// assumes ccm_pkg and the controller model are compiled first
module tb_ccm_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, fl = 1'b0, pl = 1'b0;
   logic sk = 1'b0, wx, ci;
   logic [1:0] sm, ac;
   logic [3:0] pb = 4'h4;
   logic awready, wready, bvalid, arready, rvalid, run, flt, irq;
   logic [1:0] rresp;
   logic [31:0] rdata;
   logic [2:0] wr, warn;
   logic [15:0] wd;
   int failures = 0, comparisons = 0;
   always #25 clock = ~clock;
   ccm_ctrl_model u_ccm_ctrl_model (.clock(clock), .ch_wr(wr),
      .ch_wr_ext(wx), .ch_wr_data(wd), .comm_warn(warn));
   ccm_monitor #(.TICK_CYCLES(4)) u_ccm_monitor (.clock(clock),
      .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ch_wr(wr), .ch_wr_ext(wx),
      .ch_wr_data(wd), .comm_warn(warn), .forced_local(fl),
      .stop_key(sk), .local_run_word(16'h000F), .stop_done(1'b0),
      .motor_run(run), .stop_mode(sm), .fault(flt), .comm_intr(ci),
      .active_channel(ac), .pdo_load(pl), .pdo_bytes(pb),
      .pdo_data(64'h4444_3333_2222_1111), .irq(irq));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      chk(rd & m, e);
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clock);
      failures++;
      tally_and_finish();
   end
   initial
   begin
      do_reset();
      rc(ccm_pkg::A_CTRL, 32'hFFFFFFFF, ccm_pkg::CTRL_RST);
      rc(ccm_pkg::A_DELAY, 32'hFFFFFFFF, ccm_pkg::DELAY_RST);
      rc(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk(32'(rresp), 32'(ccm_pkg::RESP_SLVERR));
      u_ccm_ctrl_model.warn(1, 3);
      rc(ccm_pkg::A_IRQ, 32'hF, 32'h0);
      u_ccm_ctrl_model.send(1, 16'h00AA);
      u_ccm_ctrl_model.send(0, 16'h0006);
      rc(ccm_pkg::A_STATUS, 32'h3F, 32'h19);
      rc(ccm_pkg::A_CMD, 32'hFFFF, 32'h6);
      chk(32'(ac), 32'h0);
      u_ccm_ctrl_model.send_ext(0, 16'h1234);
      rc(ccm_pkg::A_EXT, 32'hFFFF, 32'h1234);
      rc(ccm_pkg::A_CWI1, 32'hFFFF, 32'hAA);
      $display("test channels done");
      u_ccm_ctrl_model.send(0, 16'h0007);
      u_ccm_ctrl_model.send(0, 16'h000F);
      repeat (3) @(posedge clock);
      chk(32'(run), 32'h1);
      rc(ccm_pkg::A_OSW, 32'h42FF, 32'h237);
      sk <= 1'b1;
      repeat (4) @(posedge clock);
      rc(ccm_pkg::A_OSW, 32'h4004, 32'h4000);
      sk <= 1'b0;
      wr_reg(ccm_pkg::A_MASK, 32'h1);
      u_ccm_ctrl_model.warn(0, 3);
      chk(32'({irq, flt, ci, sm}), 32'h1D);
      rc(ccm_pkg::A_IRQ, 32'h7, 32'h5);
      rc(ccm_pkg::A_IRQ, 32'h7, 32'h5);
      chk(32'(irq), 32'h0);
      rc(ccm_pkg::A_STATUS, 32'h8, 32'h0);
      $display("test interruption done");
      do_reset();
      wr_reg(ccm_pkg::A_DELAY, 32'h20);
      u_ccm_ctrl_model.send(0, 16'h0006);
      fl <= 1'b1;
      repeat (4) @(posedge clock);
      rc(ccm_pkg::A_STATUS, 32'h108, 32'h100);
      fl <= 1'b0;
      repeat (4) @(posedge clock);
      rc(ccm_pkg::A_CMD, 32'hFFFF, 32'hF);
      rc(ccm_pkg::A_STATUS, 32'h600, 32'h200);
      repeat (140) @(posedge clock);
      rc(ccm_pkg::A_STATUS, 32'h200, 32'h0);
      rc(ccm_pkg::A_OSW, 32'h7, 32'h1);
      u_ccm_ctrl_model.send(0, 16'h000F);
      repeat (2) @(posedge clock);
      chk(32'(run), 32'h1);
      $display("test forced local done");
      pl <= 1'b1;
      @(posedge clock);
      pl <= 1'b0;
      rc(8'h30, 32'hFFFF, 32'h2222);
      rc(8'h34, 32'hFFFF, 32'h0);
      pb <= 4'h8;
      pl <= 1'b1;
      @(posedge clock);
      pl <= 1'b0;
      rc(8'h38, 32'hFFFF, 32'h4444);
      $display("test process image done");
      tally_and_finish();
   end
endmodule
